// file: sars_sequencer.sv
// Top of the converter sequencer: registers, sample/hold control and SUCCESSIVE_APPROX_REG decisions.
`timescale 1ns/1ps
module sars_sequencer (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// CPU register port.
	input  wire logic [15:0] cpu_addr,
	input  wire logic        cpu_wr,
	input  wire logic        cpu_rd,
	input  wire logic [7:0]  cpu_wdata,
	output logic      [7:0]  cpu_rdata,
	// Power state.
	input  wire logic        standby,
	// Analog front end.
	input  wire logic        comparator_high,
	output logic      [2:0]  channel_sel,
	output logic             sample_en,
	output logic      [7:0]  tap_code,
	// Conversion end request.
	output logic             conversion_end_irq
);
	// Step timer link.
	sars_step_if st ();

	typedef struct packed {
		logic [7:0]           mode;
		logic [7:0]           channel;
		logic [7:0]           result;
		logic [7:0]           successive_approx_reg;
		logic [2:0]           bit_idx;
		logic                 sample_step;
		sars_pkg::sars_phase_t phase;
		logic                 irq;
		logic                 pend;
		logic [7:0]           pend_val;
		logic [7:0]           rdata;
	} sars_state_t;

	sars_state_t s;
	sars_state_t next_s;
	logic        wr_mode;
	logic        wr_chan;
	logic        rd_res;
	logic        enable;
	logic        done;
	logic [7:0]  decided;

	// ========================================================================
	// Register decode.
	assign wr_mode = cpu_wr && cpu_addr == sars_pkg::ADDR_MODE;
	assign wr_chan = cpu_wr && cpu_addr == sars_pkg::ADDR_CHANNEL;
	assign rd_res  = cpu_rd && cpu_addr == sars_pkg::ADDR_RESULT;
	assign enable  = s.mode[sars_pkg::MODE_ENABLE_BIT] && !standby; // R15

	// Timer control: restarts on any control write.
	assign st.restart = wr_mode || wr_chan || s.phase == sars_pkg::SARS_IDLE; // R12
	assign st.run     = enable;
	assign st.periods = sars_pkg::conv_periods(s.mode[sars_pkg::MODE_TIME_LSB +: 3]); // R20

	// The current bit decision, kept when the input is at or above the tap.
	always_comb begin
		decided = s.successive_approx_reg;
		if (!comparator_high) begin
			decided[s.bit_idx] = 1'b0; // R6 R7 R24
		end
	end
	assign done = s.phase == sars_pkg::SARS_DECIDE && st.step && s.bit_idx == 3'h0;

	// ========================================================================
	// Next-state logic.
	always_comb begin
		next_s = s;
		next_s.irq = 1'b0;
		// Register writes; reserved bits are kept at zero.
		if (wr_mode) begin
			next_s.mode = cpu_wdata & sars_pkg::MODE_WMASK; // R20
		end
		if (wr_chan) begin
			next_s.channel = cpu_wdata & sars_pkg::CHANNEL_WMASK; // R2 R3 R4
		end
		// Read data captured from the current registers before any update.
		case (cpu_addr)
			sars_pkg::ADDR_MODE:    next_s.rdata = s.mode;
			sars_pkg::ADDR_CHANNEL: next_s.rdata = s.channel;
			sars_pkg::ADDR_RESULT:  next_s.rdata = s.pend ? s.pend_val : s.result; // R17
			default:                next_s.rdata = 8'h00;
		endcase
		// A deferred result lands the cycle after a colliding read.
		if (s.pend) begin
			next_s.result = s.pend_val; // R17
			next_s.pend = 1'b0;
		end
		// Sequencing.
		if (!enable || (wr_mode && !cpu_wdata[sars_pkg::MODE_ENABLE_BIT])) begin
			next_s.phase = sars_pkg::SARS_IDLE; // R13 R15
		end else if (wr_mode || wr_chan || s.phase == sars_pkg::SARS_IDLE) begin
			next_s.phase = sars_pkg::SARS_SAMPLE; // R10 R12 R14 R18
			next_s.sample_step = 1'b0;
			next_s.successive_approx_reg = 8'h80;
			next_s.bit_idx = 3'h7;
		end else if (st.step) begin
			case (s.phase)
				sars_pkg::SARS_SAMPLE: begin
					next_s.sample_step = 1'b1;
					if (s.sample_step) begin
						next_s.phase = sars_pkg::SARS_DECIDE; // R5
					end
				end
				sars_pkg::SARS_DECIDE: begin
					if (done) begin
						// Latch and request, then start the next conversion.
						if (rd_res) begin
							next_s.pend = 1'b1; // R17
							next_s.pend_val = decided;
						end else begin
							next_s.result = decided; // R8 R9
						end
						next_s.irq = 1'b1; // R8
						next_s.phase = sars_pkg::SARS_SAMPLE; // R11
						next_s.sample_step = 1'b0;
						next_s.successive_approx_reg = 8'h80;
						next_s.bit_idx = 3'h7;
					end else begin
						next_s.successive_approx_reg = decided;
						next_s.successive_approx_reg[s.bit_idx - 3'h1] = 1'b1; // R7
						next_s.bit_idx = s.bit_idx - 3'h1;
					end
				end
				default: next_s.phase = sars_pkg::SARS_IDLE;
			endcase
		end
	end

	// State register; the result is cleared only for tidiness and must not be relied on.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0; // R19
			s.mode <= sars_pkg::MODE_RESET; // R21
			s.channel <= sars_pkg::CHANNEL_RESET; // R1
		end else begin
			s <= next_s;
		end
	end

	// ========================================================================
	// Step timer.
	sars_step_timer u_timer (
		.clk   (clk),
		.rst_n (rst_n),
		.st    (st.tmr)
	);

	// Outputs. The end flag itself lives in the interrupt controller (R22).
	assign cpu_rdata          = s.rdata;
	assign channel_sel        = s.channel[2:0]; // R2
	assign sample_en          = s.phase == sars_pkg::SARS_SAMPLE; // R5
	assign tap_code           = s.successive_approx_reg; // R24
	assign conversion_end_irq = s.irq;
endmodule : sars_sequencer

// file: sars_pkg.sv
// Package of register map, field layout, reset values and timing for the converter sequencer.
// ============================================================================
// Overview of operation
// [R1] Reset clears channel select to zero.
// [R2] Bits 2..0 choose analog input 0..7.
// [R3] Software writes zeros to bits 3..7.
// [R4] Software may write single bits or bytes.
// [R5] Sample for fixed time, then hold.
// [R6] First set bit 7, mid-scale tap.
// [R7] Lower bits set tentatively, keep if above.
// [R8] After bit 0 latch result, raise request.
// [R9] Code is INT(vin/vref*256+0.5).
// [R10] Only the enable bit starts conversion.
// [R11] Conversions repeat while enable stays set.
// [R12] Writes during conversion abort and restart.
// [R13] Mode write with enable clear stops.
// [R14] First result undefined; software discards it.
// [R15] Standby halts all conversion activity.
// [R16] Software clears enable before standby.
// [R17] Result read wins over result update.
// [R18] Register write wins; no latch, no request.
// [R19] Result register not initialised by reset; the code clears it to zero with the rest of the state.
// [R20] Mode: enable bit 7, time code 5..3.
// [R21] Reset clears mode register to zero.
// [R22] Mode write does not clear end flag.
// [R23] Sampling and decisions spread over count.
// [R24] Comparator synchronous; tap is 8-bit code.
// ============================================================================
package sars_pkg;

	// Register addresses.
	localparam logic [15:0] ADDR_MODE    = 16'hFF80;
	localparam logic [15:0] ADDR_CHANNEL = 16'hFF84;
	localparam logic [15:0] ADDR_RESULT  = 16'hFF85;

	// Field positions and reset values.
	localparam int         MODE_ENABLE_BIT = 7;
	localparam int         MODE_TIME_LSB   = 3;
	localparam logic [7:0] MODE_RESET      = 8'h00;
	localparam logic [7:0] CHANNEL_RESET   = 8'h00;
	localparam logic [7:0] MODE_WMASK      = 8'hB8;
	localparam logic [7:0] CHANNEL_WMASK   = 8'h07;

	// Conversion times in clock periods per time code.
	localparam logic [7:0] TIME_CODE0 = 8'h90;
	localparam logic [7:0] TIME_CODE1 = 8'h78;
	localparam logic [7:0] TIME_CODE2 = 8'h60;
	localparam logic [7:0] TIME_CODE4 = 8'h48;
	localparam logic [7:0] TIME_CODE5 = 8'h3C;
	localparam logic [7:0] TIME_CODE6 = 8'h30;

	// Sequencer phases.
	typedef enum logic [1:0] {SARS_IDLE, SARS_SAMPLE, SARS_DECIDE} sars_phase_t;

	// Conversion time for a code; prohibited codes fall back to the slowest.
	function automatic logic [7:0] conv_periods(input logic [2:0] code);
		case (code)
			3'h1:    conv_periods = TIME_CODE1;
			3'h2:    conv_periods = TIME_CODE2;
			3'h4:    conv_periods = TIME_CODE4;
			3'h5:    conv_periods = TIME_CODE5;
			3'h6:    conv_periods = TIME_CODE6;
			default: conv_periods = TIME_CODE0;
		endcase
	endfunction : conv_periods

endpackage : sars_pkg

// file: sars_step_if.sv
// Interface carrying the step timing between the sequencer and its step timer.
`timescale 1ns/1ps
interface sars_step_if;
	logic       restart;
	logic       run;
	logic [7:0] periods;
	logic       step;
	modport ctrl (output restart, output run, output periods, input step);
	modport tmr  (input restart, input run, input periods, output step);
endinterface : sars_step_if

// file: sars_step_timer.sv
// Step timer: divides a conversion time into ten equal-rate step pulses.
`timescale 1ns/1ps
module sars_step_timer (
	// Clock and reset.
	input wire logic  clk,
	input wire logic  rst_n,
	// Timing link to the sequencer.
	sars_step_if.tmr  st
);
	typedef struct packed {
		logic [7:0] acc;
	} sars_tmr_state_t;

	sars_tmr_state_t s;
	sars_tmr_state_t next_s;
	logic [7:0]      sum;
	logic            due;

	// Ten steps (two sample, eight decisions) per conversion time: the accumulator gains
	// ten per cycle and a step falls due each time it passes the period count, so the
	// tenth step lands exactly at the end of the count with no rounding loss.
	always_comb begin
		sum = s.acc + 8'h0A;
		due = sum >= st.periods;
		next_s = s;
		if (st.restart || !st.run) begin
			next_s.acc = 8'h00;
		end else if (due) begin
			next_s.acc = sum - st.periods;
		end else begin
			next_s.acc = sum;
		end
	end

	assign st.step = st.run && !st.restart && due; // R23

	// State register.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : sars_step_timer

// file: sars_sva.sv
// Checker of port timing for the converter sequencer.
`timescale 1ns/1ps
module sars_sva (
	// Watched ports.
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic [15:0] cpu_addr,
	input wire logic        cpu_wr,
	input wire logic [7:0]  cpu_wdata,
	input wire logic [7:0]  cpu_rdata,
	input wire logic        standby,
	input wire logic [2:0]  channel_sel,
	input wire logic        sample_en,
	input wire logic [7:0]  tap_code,
	input wire logic        conversion_end_irq
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic wm;
	logic wc;
	// Decoded register writes.
	assign wm = cpu_wr && cpu_addr == sars_pkg::ADDR_MODE;
	assign wc = cpu_wr && cpu_addr == sars_pkg::ADDR_CHANNEL;
	a_irq_single_pulse: assert property (conversion_end_irq |=> !conversion_end_irq)
		else $error("irq wider than one cycle");
	a_sample_mid_tap: assert property ($rose(sample_en) |-> tap_code == 8'h80)
		else $error("tap not mid-scale at sampling");
	a_hold_kept: assert property ($fell(sample_en) ##1 (!cpu_wr) [*3] |=> !sample_en)
		else $error("hold released early");
	a_write_no_irq: assert property (wm || wc |=> (!conversion_end_irq) [*8])
		else $error("irq after register write");
	a_stop_quiet: assert property (wm && !cpu_wdata[7] |-> ##2 (!conversion_end_irq && !sample_en) [*8])
		else $error("activity after stop");
	a_standby_halt: assert property (standby && $past(standby) |-> !conversion_end_irq && $stable(tap_code))
		else $error("activity in standby");
	a_channel_load: assert property (wc |=> channel_sel == $past(cpu_wdata[2:0]))
		else $error("channel not loaded");
	a_channel_read: assert property (cpu_addr == sars_pkg::ADDR_CHANNEL && !cpu_wr |=> cpu_rdata == {5'h00, $past(channel_sel)})
		else $error("channel readback wrong");
	c_end: cover property (conversion_end_irq);
	c_abort: cover property (wc && !sample_en);
	c_standby: cover property (standby [*2]);
endmodule : sars_sva
bind sars_sequencer sars_sva u_sva (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wr(cpu_wr),
	.cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .standby(standby), .channel_sel(channel_sel),
	.sample_en(sample_en), .tap_code(tap_code), .conversion_end_irq(conversion_end_irq));

// file: sars_analog_model.sv
// Far-side model: sample-hold and comparator against the tap code.
`timescale 1ns/1ps
module sars_analog_model (
	// Input levels, one byte per channel.
	input wire logic [63:0] levels,
	// Converter side.
	input wire logic        clk,
	input wire logic [2:0]  channel_sel,
	input wire logic        sample_en,
	input wire logic [7:0]  tap_code,
	output logic            comparator_high
);
	logic [7:0] held;
	// Track the input while sampling and keep it while holding.
	always_ff @(posedge clk) if (sample_en) held <= levels[channel_sel*8 +: 8];
	// The held byte is the ideal rounded code, so the search must end on it.
	assign comparator_high = held >= tap_code;
endmodule : sars_analog_model

// file: sars_tb.sv
// Self-checking bench for the converter sequencer.
`timescale 1ns/1ps
module testbench;
	localparam logic [15:0] AM = sars_pkg::ADDR_MODE;
	localparam logic [15:0] AC = sars_pkg::ADDR_CHANNEL;
	localparam logic [15:0] AR = sars_pkg::ADDR_RESULT;
	logic        clk, rst_n, wr_s, rd_s, standby, cmp, smp, irq;
	logic [15:0] addr;
	logic [7:0]  wdata, rdata, tap;
	logic [2:0]  chan;
	logic [63:0] levels;
	int          n_mismatch, samples_checked, cnt;
	sars_sequencer u_dut (.clk(clk), .rst_n(rst_n), .cpu_addr(addr), .cpu_wr(wr_s), .cpu_rd(rd_s),
		.cpu_wdata(wdata), .cpu_rdata(rdata), .standby(standby), .comparator_high(cmp),
		.channel_sel(chan), .sample_en(smp), .tap_code(tap), .conversion_end_irq(irq));
	sars_analog_model u_far (.levels(levels), .clk(clk), .channel_sel(chan), .sample_en(smp),
		.tap_code(tap), .comparator_high(cmp));
	// Clock of 5 ns period.
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr_s = 1'b1;
		@(negedge clk);
		wr_s = 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd_s = 1'b1;
		@(negedge clk);
		rd_s = 1'b0;
		chk(rdata, exp);
	endtask : rd
	task automatic wait_irq();
		cnt = 0;
		do begin
			@(negedge clk);
			cnt++;
		end while (irq !== 1'b1 && cnt < 400);
		chk(8'(irq), 8'h01);
	endtask : wait_irq
	task automatic quiet();
		cnt = 0;
		repeat (300) begin
			@(negedge clk);
			if (irq !== 1'b0) cnt++;
		end
		chk(8'(cnt), 8'h00);
	endtask : quiet
	task automatic tally_and_finish();
		$display("mismatches %0d checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	// Watchdog against a hang.
	initial begin
		#50000;
		n_mismatch++;
		tally_and_finish();
	end
	// Main sequence of register accesses and conversions.
	initial begin
		n_mismatch = 0;
		samples_checked = 0;
		{rst_n, wr_s, rd_s, standby, addr, wdata} = '0;
		for (int i = 0; i < 8; i++) levels[i*8 +: 8] = 8'(8'h05 + 8'h21 * i);
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		rd(AM, 8'h00);
		rd(AC, 8'h00);
		rd(16'hFF86, 8'h00);
		wr(AC, 8'hFF);
		rd(AC, 8'h07);
		for (int i = 0; i < 8; i++) begin
			wr(AC, 8'(i));
			wr(AM, 8'hB0);
			wait_irq();
			wait_irq();
			rd(AR, levels[i*8 +: 8]);
		end
		rd(AM, 8'hB0);
		wr(AM, 8'hFF);
		rd(AM, 8'hB8);
		repeat (60) @(negedge clk);
		wr(AC, 8'h03);
		wait_irq();
		chk(8'(cnt), sars_pkg::TIME_CODE0);
		// The next result lands one full count on; a read on that very edge sees the old one.
		levels[24 +: 8] = 8'h5A;
		repeat (142) @(negedge clk);
		rd(AR, 8'h68);
		rd(AR, 8'h5A);
		// A channel write on the following end edge suppresses both latch and request.
		levels[24 +: 8] = 8'h33;
		repeat (140) @(negedge clk);
		wr(AC, 8'h03);
		chk(8'(irq), 8'h00);
		rd(AR, 8'h5A);
		wait_irq();
		rd(AR, 8'h33);
		wr(AM, 8'h30);
		quiet();
		wr(AM, 8'hB0);
		standby = 1'b1;
		quiet();
		standby = 1'b0;
		wait_irq();
		wr(AM, 8'h30);
		standby = 1'b1;
		quiet();
		tally_and_finish();
	end
endmodule : testbench
